// [rsi_top.v]
// Processor architectural state initializer with AXI4-Lite access
`timescale 1ns/100ps
`include "rsi_defines.vh"
module rsi_top #(
  parameter BUILTIN_SELF_TEST_CYCLES = 30000000
) (
  input wire i_ref_clk,
  input wire i_resetn,
  input wire i_clk_en,
  input wire i_hw_reset,
  input wire i_warm_init,
  input wire i_builtin_self_test_strap,
  input wire i_builtin_self_test_fault,
  input wire i_fpu_init_instruction,
  input wire [7:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output wire o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output wire o_s_axi_wready,
  output reg [1:0] o_s_axi_bresp,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire [7:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output wire o_s_axi_arready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  output reg [31:0] o_control_register_zero,
  output reg o_cache_valid,
  output reg o_tlb_valid,
  output reg o_btb_valid,
  output reg o_memory_type_ranges_en,
  output reg o_local_interrupt_controller_en,
  output wire o_builtin_self_test_busy
);
  // ============================================================
  // Byte-lane merge and control register zero reset helpers
  function [31:0] merge32;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer b;
    begin
      merge32 = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge32[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0] strb;
    begin
      merge16 = old_v;
      if (strb[0]) begin
        merge16[7:0] = new_v[7:0];
      end
      if (strb[1]) begin
        merge16[15:8] = new_v[15:8];
      end
    end
  endfunction

  function [31:0] cr0_after_reset;
    input [31:0] old_v;
    begin
      cr0_after_reset = (old_v & `RSI_CR0_KEEP) | `RSI_CR0_FORCE;
    end
  endfunction

  // ============================================================
  // Pin synchronisers and self-test
  wire [2:0] pins_sync;
  wire builtin_self_test_done;
  wire [31:0] builtin_self_test_result;
  reg builtin_self_test_start;
  reg hw_prev;
  reg warm_prev;
  reg [1:0] settle;

  rsi_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_async({i_builtin_self_test_strap, i_warm_init, i_hw_reset}),
    .o_sync(pins_sync)
  );

  rsi_builtin_self_test #(
    .BUILTIN_SELF_TEST_CYCLES(BUILTIN_SELF_TEST_CYCLES)
  ) u_builtin_self_test (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_start(builtin_self_test_start),
    .i_fault(i_builtin_self_test_fault),
    .o_busy(o_builtin_self_test_busy),
    .o_done(builtin_self_test_done),
    .o_result(builtin_self_test_result)
  );

  wire hw_rst = pins_sync[`RSI_PIN_HWRST];
  wire strap = pins_sync[`RSI_PIN_STRAP];
  wire cold_evt = hw_rst;
  wire warm_evt = pins_sync[`RSI_PIN_WARM] && !warm_prev && !hw_rst;
  wire finit_evt = i_fpu_init_instruction && !hw_rst && !warm_evt;

  // Self-test only from power-up settle or hardware reset release
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hw_prev <= 1'b0;
      warm_prev <= 1'b0;
      settle <= `RSI_SETTLE_INIT;
      builtin_self_test_start <= 1'b0;
    end else if (i_clk_en) begin
      hw_prev <= hw_rst;
      warm_prev <= pins_sync[`RSI_PIN_WARM];
      builtin_self_test_start <= 1'b0;
      if (settle != 2'h0) begin
        settle <= settle - 2'h1;
        if (settle == 2'h1) begin
          builtin_self_test_start <= strap;
        end
      end else if (hw_prev && !hw_rst) begin
        builtin_self_test_start <= strap;
      end
    end
  end

  // ============================================================
  // Architectural state
  reg [15:0] fpu_cw;
  reg [15:0] fpu_sw;
  reg [15:0] fpu_tw;
  reg [15:0] fpu_dsel;
  reg [15:0] fpu_csel;
  reg [31:0] fpu_dptr;
  reg [31:0] fpu_iptr;
  reg [31:0] simd_control_status;
  reg [`RSI_FLAGS_W-1:0] flags_word;
  reg [31:0] accumulator;
  reg [63:0] tsc;
  reg [31:0] perf_cnt;
  reg [31:0] perf_sel;
  reg [31:0] mtr_data;
  reg [63:0] packed_integer_regs [0:7];
  reg [2:0] pk_idx;
  reg [1:0] last_cause;
  integer i;

  // ============================================================
  // AXI4-Lite write path
  reg aw_full;
  reg w_full;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg wr_hit;

  assign o_s_axi_awready = !aw_full && !o_s_axi_bvalid;
  assign o_s_axi_wready = !w_full && !o_s_axi_bvalid;
  wire wr_go = aw_full && w_full && !o_s_axi_bvalid;

  always @* begin
    case (aw_addr)
      `RSI_OFS_FPU_CW, `RSI_OFS_FPU_SW, `RSI_OFS_FPU_TW,
      `RSI_OFS_FPU_DSEL, `RSI_OFS_FPU_CSEL, `RSI_OFS_FPU_DPTR,
      `RSI_OFS_FPU_IPTR, `RSI_OFS_SIMD_CS, `RSI_OFS_CR0,
      `RSI_OFS_FLAGS, `RSI_OFS_PERF_SEL, `RSI_OFS_MTR_CTL,
      `RSI_OFS_MTR_DATA, `RSI_OFS_LIC_CTL, `RSI_OFS_FILL,
      `RSI_OFS_PK_IDX, `RSI_OFS_PK_LO, `RSI_OFS_PK_HI: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= `RSI_ZERO32;
      w_strb <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `RSI_RESP_OKAY;
    end else if (i_clk_en) begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= {i_s_axi_awaddr[7:2], 2'h0};
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= wr_hit ? `RSI_RESP_OKAY : `RSI_RESP_SLVERR;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ============================================================
  // State update: software writes, then init causes
  wire [63:0] pk_cur = packed_integer_regs[pk_idx];

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fpu_cw <= `RSI_CW_RESET;
      fpu_sw <= `RSI_SW_INIT;
      fpu_tw <= `RSI_TW_RESET;
      fpu_dsel <= `RSI_SEL_INIT;
      fpu_csel <= `RSI_SEL_INIT;
      fpu_dptr <= `RSI_PTR_INIT;
      fpu_iptr <= `RSI_PTR_INIT;
      simd_control_status <= `RSI_SIMD_RESET;
      o_control_register_zero <= `RSI_CR0_POWERUP;
      flags_word <= `RSI_FLAGS_RESET;
      accumulator <= `RSI_ZERO32;
      tsc <= `RSI_ZERO64;
      perf_cnt <= `RSI_ZERO32;
      perf_sel <= `RSI_ZERO32;
      o_memory_type_ranges_en <= 1'b0;
      mtr_data <= `RSI_ZERO32;
      o_local_interrupt_controller_en <= 1'b1;
      o_cache_valid <= 1'b0;
      o_tlb_valid <= 1'b0;
      o_btb_valid <= 1'b0;
      pk_idx <= 3'h0;
      last_cause <= `RSI_CAUSE_POWER;
      for (i = 0; i < 8; i = i + 1) begin
        packed_integer_regs[i] <= `RSI_PK_INIT;
      end
    end else if (i_clk_en) begin
      tsc <= tsc + 64'h1;
      if (perf_sel[`RSI_SEL_CYCLES] ||
          (perf_sel[`RSI_SEL_FINITS] && finit_evt)) begin
        perf_cnt <= perf_cnt + 32'h1;
      end
      if (wr_go) begin
        case (aw_addr)
          `RSI_OFS_FPU_CW: fpu_cw <= merge16(fpu_cw, w_data[15:0], w_strb[1:0]);
          `RSI_OFS_FPU_SW: fpu_sw <= merge16(fpu_sw, w_data[15:0], w_strb[1:0]);
          `RSI_OFS_FPU_TW: fpu_tw <= merge16(fpu_tw, w_data[15:0], w_strb[1:0]);
          `RSI_OFS_FPU_DSEL: begin
            fpu_dsel <= merge16(fpu_dsel, w_data[15:0], w_strb[1:0]);
          end
          `RSI_OFS_FPU_CSEL: begin
            fpu_csel <= merge16(fpu_csel, w_data[15:0], w_strb[1:0]);
          end
          `RSI_OFS_FPU_DPTR: fpu_dptr <= merge32(fpu_dptr, w_data, w_strb);
          `RSI_OFS_FPU_IPTR: fpu_iptr <= merge32(fpu_iptr, w_data, w_strb);
          `RSI_OFS_SIMD_CS: begin
            simd_control_status <= merge32(simd_control_status, w_data, w_strb);
          end
          `RSI_OFS_CR0: begin
            o_control_register_zero <=
              merge32(o_control_register_zero, w_data, w_strb);
          end
          `RSI_OFS_FLAGS: begin
            flags_word <= w_data[`RSI_FLAGS_W-1:0];
          end
          `RSI_OFS_PERF_SEL: perf_sel <= merge32(perf_sel, w_data, w_strb);
          `RSI_OFS_MTR_CTL: begin
            if (w_strb[0]) begin
              o_memory_type_ranges_en <= w_data[0];
            end
          end
          `RSI_OFS_MTR_DATA: mtr_data <= merge32(mtr_data, w_data, w_strb);
          `RSI_OFS_LIC_CTL: begin
            if (w_strb[0]) begin
              o_local_interrupt_controller_en <= w_data[0];
            end
          end
          `RSI_OFS_FILL: begin
            if (w_data[`RSI_FILL_CACHE]) begin
              o_cache_valid <= 1'b1;
            end
            if (w_data[`RSI_FILL_TLB]) begin
              o_tlb_valid <= 1'b1;
            end
            if (w_data[`RSI_FILL_BTB]) begin
              o_btb_valid <= 1'b1;
            end
          end
          `RSI_OFS_PK_IDX: begin
            if (w_strb[0]) begin
              pk_idx <= w_data[2:0];
            end
          end
          `RSI_OFS_PK_LO: begin
            packed_integer_regs[pk_idx] <=
              {pk_cur[63:32], merge32(pk_cur[31:0], w_data, w_strb)};
          end
          `RSI_OFS_PK_HI: begin
            packed_integer_regs[pk_idx] <=
              {merge32(pk_cur[63:32], w_data, w_strb), pk_cur[31:0]};
          end
          default: begin
          end
        endcase
      end
      if (finit_evt) begin
        fpu_cw <= `RSI_CW_FINIT;
        fpu_sw <= `RSI_SW_INIT;
        fpu_tw <= `RSI_TW_FINIT;
        fpu_dsel <= `RSI_SEL_INIT;
        fpu_csel <= `RSI_SEL_INIT;
        fpu_dptr <= `RSI_PTR_INIT;
        fpu_iptr <= `RSI_PTR_INIT;
        last_cause <= `RSI_CAUSE_FINIT;
      end
      // Warm init touches only mode, translation, branch target, flags, accumulator and last cause state
      if (warm_evt) begin
        o_tlb_valid <= 1'b0;
        o_btb_valid <= 1'b0;
        o_control_register_zero <= cr0_after_reset(o_control_register_zero);
        flags_word <= `RSI_FLAGS_RESET;
        accumulator <= `RSI_ZERO32;
        last_cause <= `RSI_CAUSE_WARM;
      end
      if (cold_evt) begin
        fpu_cw <= `RSI_CW_RESET;
        fpu_sw <= `RSI_SW_INIT;
        fpu_tw <= `RSI_TW_RESET;
        fpu_dsel <= `RSI_SEL_INIT;
        fpu_csel <= `RSI_SEL_INIT;
        fpu_dptr <= `RSI_PTR_INIT;
        fpu_iptr <= `RSI_PTR_INIT;
        simd_control_status <= `RSI_SIMD_RESET;
        o_control_register_zero <= cr0_after_reset(o_control_register_zero);
        flags_word <= `RSI_FLAGS_RESET;
        accumulator <= `RSI_ZERO32;
        tsc <= `RSI_ZERO64;
        perf_cnt <= `RSI_ZERO32;
        perf_sel <= `RSI_ZERO32;
        o_memory_type_ranges_en <= 1'b0;
        mtr_data <= `RSI_ZERO32;
        o_local_interrupt_controller_en <= 1'b1;
        o_cache_valid <= 1'b0;
        o_tlb_valid <= 1'b0;
        o_btb_valid <= 1'b0;
        last_cause <= `RSI_CAUSE_HWRST;
        for (i = 0; i < 8; i = i + 1) begin
          packed_integer_regs[i] <= `RSI_PK_INIT;
        end
      end else if (builtin_self_test_done) begin
        accumulator <= builtin_self_test_result;
      end
    end
  end

  // ============================================================
  // AXI4-Lite read path
  reg [31:0] rd_word;
  reg rd_hit;
  wire [31:0] status_word = {22'h0, last_cause, 2'h0,
    o_local_interrupt_controller_en, o_memory_type_ranges_en,
    o_btb_valid, o_tlb_valid, o_cache_valid, o_builtin_self_test_busy};
  wire [63:0] pk_rd = packed_integer_regs[pk_idx];

  assign o_s_axi_arready = !o_s_axi_rvalid;

  always @* begin
    rd_hit = 1'b1;
    case ({i_s_axi_araddr[7:2], 2'h0})
      `RSI_OFS_STATUS: rd_word = status_word;
      `RSI_OFS_FPU_CW: rd_word = {16'h0, fpu_cw};
      `RSI_OFS_FPU_SW: rd_word = {16'h0, fpu_sw};
      `RSI_OFS_FPU_TW: rd_word = {16'h0, fpu_tw};
      `RSI_OFS_FPU_DSEL: rd_word = {16'h0, fpu_dsel};
      `RSI_OFS_FPU_CSEL: rd_word = {16'h0, fpu_csel};
      `RSI_OFS_FPU_DPTR: rd_word = fpu_dptr;
      `RSI_OFS_FPU_IPTR: rd_word = fpu_iptr;
      `RSI_OFS_SIMD_CS: rd_word = simd_control_status;
      `RSI_OFS_CR0: rd_word = o_control_register_zero;
      `RSI_OFS_FLAGS: rd_word = {10'h0, flags_word};
      `RSI_OFS_ACC: rd_word = accumulator;
      `RSI_OFS_TSC_LO: rd_word = tsc[31:0];
      `RSI_OFS_TSC_HI: rd_word = tsc[63:32];
      `RSI_OFS_PERF_CNT: rd_word = perf_cnt;
      `RSI_OFS_PERF_SEL: rd_word = perf_sel;
      `RSI_OFS_MTR_CTL: rd_word = {31'h0, o_memory_type_ranges_en};
      `RSI_OFS_MTR_DATA: rd_word = mtr_data;
      `RSI_OFS_LIC_CTL: rd_word = {31'h0, o_local_interrupt_controller_en};
      `RSI_OFS_FILL: rd_word = `RSI_ZERO32;
      `RSI_OFS_PK_IDX: rd_word = {29'h0, pk_idx};
      `RSI_OFS_PK_LO: rd_word = pk_rd[31:0];
      `RSI_OFS_PK_HI: rd_word = pk_rd[63:32];
      default: begin
        rd_word = `RSI_ZERO32;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= `RSI_ZERO32;
      o_s_axi_rresp <= `RSI_RESP_OKAY;
    end else if (i_clk_en) begin
      if (i_s_axi_arvalid && o_s_axi_arready) begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata <= rd_word;
        o_s_axi_rresp <= rd_hit ? `RSI_RESP_OKAY : `RSI_RESP_SLVERR;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// [rsi_defines.vh]
// Constants for the processor reset state initializer
// Overview of operation
// - Power-up or hardware reset loads the fpu control word with 0040H; the fpu init instruction loads 037FH.
// - The fpu status word and both fpu selectors read 0000H after power-up, hardware reset and the fpu init instruction.
// - Power-up or hardware reset loads the fpu tag word with 5555H; the fpu init instruction loads FFFFH.
// - The eight packed integer registers clear on power-up or hardware reset and keep their value on warm init and fpu init.
// - Power-up or hardware reset loads the simd control and status register with 1F80H; warm init leaves it alone.
// - The time stamp counter, perf counter and event select clear on power-up or hardware reset and keep their value on warm init.
// - Memory type ranges come out of power-up or hardware reset disabled, and warm init keeps their enable and contents.
// - The local interrupt controller is enabled after power-up or hardware reset, and warm init keeps its enable and setup.
// - The top ten bits of the flags word are left undefined after reset and are not to be relied on.
// - A reset keeps the cache disable and not write through bits of control register zero, sets bit 4 and clears the rest.
// - After self-test the accumulator is zero only when every test passed, and nonzero otherwise.
// - A warm init never starts the self-test; only power-up or hardware reset may.
// - Warm init keeps every fpu register and every packed integer register unchanged.
// - Power-up or hardware reset invalidates caches and TLBs; warm init keeps cache contents and validity.
// - After power-up control register zero holds 60000010H, real mode with paging off.
// - Warm init invalidates the TLBs and the branch target buffer as a hardware reset does.
`ifndef RSI_DEFINES_VH
`define RSI_DEFINES_VH

// ============================================================
// Register offsets
`define RSI_ADDR_W 8
`define RSI_OFS_STATUS 8'h00
`define RSI_OFS_FPU_CW 8'h04
`define RSI_OFS_FPU_SW 8'h08
`define RSI_OFS_FPU_TW 8'h0C
`define RSI_OFS_FPU_DSEL 8'h10
`define RSI_OFS_FPU_CSEL 8'h14
`define RSI_OFS_FPU_DPTR 8'h18
`define RSI_OFS_FPU_IPTR 8'h1C
`define RSI_OFS_SIMD_CS 8'h20
`define RSI_OFS_CR0 8'h24
`define RSI_OFS_FLAGS 8'h28
`define RSI_OFS_ACC 8'h2C
`define RSI_OFS_TSC_LO 8'h30
`define RSI_OFS_TSC_HI 8'h34
`define RSI_OFS_PERF_CNT 8'h38
`define RSI_OFS_PERF_SEL 8'h3C
`define RSI_OFS_MTR_CTL 8'h40
`define RSI_OFS_MTR_DATA 8'h44
`define RSI_OFS_LIC_CTL 8'h48
`define RSI_OFS_FILL 8'h4C
`define RSI_OFS_PK_IDX 8'h50
`define RSI_OFS_PK_LO 8'h54
`define RSI_OFS_PK_HI 8'h58

// ============================================================
// Reset and init values
`define RSI_CW_RESET 16'h0040
`define RSI_CW_FINIT 16'h037F
`define RSI_SW_INIT 16'h0000
`define RSI_TW_RESET 16'h5555
`define RSI_TW_FINIT 16'hFFFF
`define RSI_SEL_INIT 16'h0000
`define RSI_PTR_INIT 32'h00000000
`define RSI_PK_INIT 64'h0000000000000000
`define RSI_SIMD_RESET 32'h00001F80
`define RSI_CR0_POWERUP 32'h60000010
`define RSI_CR0_KEEP 32'h60000000
`define RSI_CR0_FORCE 32'h00000010
`define RSI_FLAGS_W 22
`define RSI_FLAGS_RESET 22'h000002
`define RSI_ZERO32 32'h00000000
`define RSI_ZERO64 64'h0000000000000000
`define RSI_BUILTIN_SELF_TEST_FAIL 32'h00000001

// ============================================================
// Field positions and codes
`define RSI_ST_BUSY 0
`define RSI_ST_CACHE 1
`define RSI_ST_TLB 2
`define RSI_ST_BTB 3
`define RSI_ST_MTR 4
`define RSI_ST_LIC 5
`define RSI_ST_CAUSE_LO 8
`define RSI_ST_CAUSE_HI 9
`define RSI_FILL_CACHE 0
`define RSI_FILL_TLB 1
`define RSI_FILL_BTB 2
`define RSI_SEL_CYCLES 0
`define RSI_SEL_FINITS 1
`define RSI_PIN_HWRST 0
`define RSI_PIN_WARM 1
`define RSI_PIN_STRAP 2
`define RSI_CAUSE_POWER 2'h0
`define RSI_CAUSE_HWRST 2'h1
`define RSI_CAUSE_WARM 2'h2
`define RSI_CAUSE_FINIT 2'h3
`define RSI_SETTLE_INIT 2'h3
`define RSI_RESP_OKAY 2'h0
`define RSI_RESP_SLVERR 2'h2

`endif

// [rsi_sync.v]
// Two-stage synchroniser for the reset, warm init and strap pins
`timescale 1ns/100ps
module rsi_sync (
  input wire i_ref_clk,
  input wire i_resetn,
  input wire i_clk_en,
  input wire [2:0] i_async,
  output reg [2:0] o_sync
);
  reg [2:0] stage1;

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stage1 <= 3'h0;
      o_sync <= 3'h0;
    end else if (i_clk_en) begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule

// [rsi_builtin_self_test.v]
// Built-in self-test sequencer with pass or fail result
`timescale 1ns/100ps
`include "rsi_defines.vh"
module rsi_builtin_self_test #(
  parameter BUILTIN_SELF_TEST_CYCLES = 30000000
) (
  input wire i_ref_clk,
  input wire i_resetn,
  input wire i_clk_en,
  input wire i_start,
  input wire i_fault,
  output reg o_busy,
  output reg o_done,
  output reg [31:0] o_result
);
  localparam [31:0] LAST_FULL = BUILTIN_SELF_TEST_CYCLES - 1;
  localparam [24:0] LAST = LAST_FULL[24:0];
  reg [24:0] count;
  reg failed;

  // ============================================================
  // Test run
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_result <= `RSI_ZERO32;
      count <= 25'h0;
      failed <= 1'b0;
    end else if (i_clk_en) begin
      o_done <= 1'b0;
      if (i_start && !o_busy) begin
        o_busy <= 1'b1;
        count <= 25'h0;
        failed <= i_fault;
      end else if (o_busy) begin
        failed <= failed | i_fault;
        if (count == LAST) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
          o_result <= (failed | i_fault) ? `RSI_BUILTIN_SELF_TEST_FAIL : `RSI_ZERO32;
        end else begin
          count <= count + 25'h1;
        end
      end
    end
  end
endmodule

// [rsi_monitor.sv]
// Assertion checker for the reset state initializer
`timescale 1ns/100ps
module rsi_monitor #(
  parameter BUILTIN_SELF_TEST_CYCLES = 30000000
) (
  input wire i_ref_clk,
  input wire i_resetn,
  input wire i_clk_en,
  input wire i_hw_reset,
  input wire i_warm_init,
  input wire i_fpu_init_instruction,
  input wire i_s_axi_arvalid,
  input wire o_s_axi_arready,
  input wire o_s_axi_rvalid,
  input wire [31:0] o_control_register_zero,
  input wire o_cache_valid,
  input wire o_tlb_valid,
  input wire o_btb_valid,
  input wire o_memory_type_ranges_en,
  input wire o_local_interrupt_controller_en,
  input wire o_builtin_self_test_busy
);
  // ====
  // Self-test length counter
  int unsigned busy_cnt;
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn)
      busy_cnt <= 0;
    else if (o_builtin_self_test_busy)
      busy_cnt <= busy_cnt + 1;
    else
      busy_cnt <= 0;
  end

  // ====
  // Properties
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  a_power_cr0: assert property (
    $rose(i_resetn) |-> o_control_register_zero == 32'h60000010)
    else $error("cr0 wrong after power-up");
  a_power_state: assert property (
    $rose(i_resetn) |-> o_local_interrupt_controller_en && !o_cache_valid
      && !o_tlb_valid && !o_btb_valid && !o_memory_type_ranges_en)
    else $error("state pins wrong after power-up");
  a_hw_cr0: assert property (
    (i_hw_reset && i_clk_en)[*4] |=>
      (o_control_register_zero & 32'h9FFFFFFF) == 32'h00000010 &&
      o_control_register_zero[30:29] == $past(o_control_register_zero[30:29]))
    else $error("cr0 wrong during hardware reset");
  a_hw_state: assert property (
    (i_hw_reset && i_clk_en)[*4] |=> !o_cache_valid && !o_tlb_valid &&
      !o_btb_valid && !o_memory_type_ranges_en &&
      o_local_interrupt_controller_en)
    else $error("state pins wrong during hardware reset");
  a_warm_inval: assert property (
    $rose(i_warm_init) && !i_hw_reset |-> ##[1:6] (!o_tlb_valid && !o_btb_valid))
    else $error("warm init left tlb or btb valid");
  a_warm_keep: assert property (
    $rose(i_warm_init) && !i_hw_reset |=> ($stable(o_cache_valid) &&
      $stable(o_memory_type_ranges_en) &&
      $stable(o_local_interrupt_controller_en))[*6])
    else $error("warm init changed kept state");
  a_warm_nobist: assert property (
    $rose(i_warm_init) && !i_hw_reset && !o_builtin_self_test_busy |=>
      (!o_builtin_self_test_busy)[*8])
    else $error("warm init started self-test");
  a_builtin_self_test_len: assert property (
    $fell(o_builtin_self_test_busy) |-> busy_cnt == BUILTIN_SELF_TEST_CYCLES)
    else $error("self-test length wrong");
  a_fpu_pins: assert property (
    i_fpu_init_instruction && !i_hw_reset && !i_warm_init |=>
      $stable(o_control_register_zero) && $stable(o_tlb_valid))
    else $error("fpu init touched cr0 or tlb");
  a_rd_answer: assert property (
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");

  c_builtin_self_test: cover property ($fell(o_builtin_self_test_busy));
  c_warm: cover property ($rose(i_warm_init));
  c_hw: cover property (i_hw_reset[*4]);
endmodule

bind rsi_top rsi_monitor #(.BUILTIN_SELF_TEST_CYCLES(BUILTIN_SELF_TEST_CYCLES)) u_mon (.*);

// [tb_top.sv]
// Self-checking bench for the reset state initializer
`timescale 1ns/100ps
module tb_top;
  logic i_ref_clk = 1'h0;
  logic i_resetn = 1'h0;
  logic i_clk_en = 1'h1;
  logic i_hw_reset = 1'h0;
  logic i_warm_init = 1'h0;
  logic i_builtin_self_test_strap = 1'h0;
  logic i_builtin_self_test_fault = 1'h0;
  logic i_fpu_init_instruction = 1'h0;
  logic i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0;
  logic i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0;
  logic [7:0] i_s_axi_awaddr = 8'h0, i_s_axi_araddr = 8'h0;
  logic [31:0] i_s_axi_wdata = 32'h0;
  logic [3:0] i_s_axi_wstrb = 4'hF;
  wire o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  wire o_s_axi_rvalid, o_cache_valid, o_tlb_valid, o_btb_valid;
  wire o_memory_type_ranges_en, o_local_interrupt_controller_en;
  wire o_builtin_self_test_busy;
  wire [1:0] o_s_axi_bresp, o_s_axi_rresp;
  wire [31:0] o_s_axi_rdata, o_control_register_zero;
  int err_count = 0, checks = 0, cyc = 0;
  logic [31:0] rv, cnt0;
  logic [1:0] resp;

  rsi_top #(.BUILTIN_SELF_TEST_CYCLES(8)) i_rsi_top (.*);

  initial forever #10 i_ref_clk = ~i_ref_clk;

  // ====
  // Timeout
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end

  // ====
  // Tasks
  task end_sim();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(string s, logic [31:0] v, logic [31:0] e);
    checks++;
    if (v !== e) begin
      err_count++;
      $display("BAD %s exp %h seen %h", s, e, v);
    end
  endtask
  task wr(logic [7:0] a, logic [31:0] d);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'h1;
    i_s_axi_wvalid <= 1'h1;
    i_s_axi_bready <= 1'h1;
    do begin
      @(posedge i_ref_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
    end while (o_s_axi_bvalid !== 1'h1);
    resp = o_s_axi_bresp;
    i_s_axi_bready <= 1'h0;
    @(posedge i_ref_clk);
  endtask
  task rd(logic [7:0] a);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'h1;
    i_s_axi_rready <= 1'h1;
    do begin
      @(posedge i_ref_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
    end while (o_s_axi_rvalid !== 1'h1);
    rv = o_s_axi_rdata;
    resp = o_s_axi_rresp;
    i_s_axi_rready <= 1'h0;
    @(posedge i_ref_clk);
  endtask
  task rc(logic [7:0] a, logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), rv, e);
  endtask
  task cold(logic [31:0] cr, logic [31:0] st);
    logic [7:0] a[14];
    logic [31:0] e[14];
    a = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20,
      8'h3C, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h54};
    e = '{32'h40, 32'h0, 32'h5555, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1F80,
      32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
    rd(8'h30);
    chk("tsc", rv < 32'h40, 32'h1);
    foreach (a[i]) rc(a[i], e[i]);
    rc(8'h24, cr);
    rc(8'h00, st);
    rc(8'h2C, 32'h0);
    rd(8'h28);
    chk("flags", rv & 32'h3FFFFF, 32'h2);
  endtask
  task hwp();
    i_hw_reset <= 1'h1;
    repeat (6) @(posedge i_ref_clk);
    i_hw_reset <= 1'h0;
    repeat (4) @(posedge i_ref_clk);
  endtask
  task warm_p();
    i_warm_init <= 1'h1;
    repeat (4) @(posedge i_ref_clk);
    i_warm_init <= 1'h0;
    repeat (8) @(posedge i_ref_clk);
  endtask

  // ====
  // Main sequence
  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_resetn <= 1'h1;
    @(posedge i_ref_clk);
    cold(32'h60000010, 32'h20);
    $display("test power-up done");
    wr(8'h3C, 32'h2);
    wr(8'h50, 32'h3);
    wr(8'h54, 32'hA5A5A5A5);
    wr(8'h58, 32'h5A5A5A5A);
    wr(8'h08, 32'hFF);
    wr(8'h10, 32'h1111);
    wr(8'h18, 32'h2222);
    wr(8'h20, 32'h1F00);
    i_fpu_init_instruction <= 1'h1;
    repeat (2) @(posedge i_ref_clk);
    i_fpu_init_instruction <= 1'h0;
    @(posedge i_ref_clk);
    rc(8'h04, 32'h37F);
    rc(8'h08, 32'h0);
    rc(8'h0C, 32'hFFFF);
    rc(8'h10, 32'h0);
    rc(8'h18, 32'h0);
    rc(8'h20, 32'h1F00);
    rc(8'h38, 32'h2);
    rc(8'h58, 32'h5A5A5A5A);
    rc(8'h00, 32'h320);
    $display("test fpu init done");
    wr(8'h04, 32'hABC);
    wr(8'h40, 32'h1);
    wr(8'h44, 32'hCAFE0001);
    wr(8'h48, 32'h0);
    wr(8'h24, 32'hE0000011);
    wr(8'h4C, 32'h7);
    warm_p();
    rc(8'h04, 32'hABC);
    rc(8'h0C, 32'hFFFF);
    rc(8'h54, 32'hA5A5A5A5);
    rc(8'h20, 32'h1F00);
    rc(8'h38, 32'h2);
    rc(8'h40, 32'h1);
    rc(8'h44, 32'hCAFE0001);
    rc(8'h48, 32'h0);
    rc(8'h24, 32'h60000010);
    rc(8'h00, 32'h212);
    $display("test warm init done");
    wr(8'h24, 32'h40000001);
    hwp();
    cold(32'h40000010, 32'h120);
    $display("test hardware reset done");
    i_builtin_self_test_strap <= 1'h1;
    for (int f = 0; f < 2; f++) begin
      i_builtin_self_test_fault <= f[0];
      hwp();
      while (o_builtin_self_test_busy !== 1'h1) @(posedge i_ref_clk);
      while (o_builtin_self_test_busy !== 1'h0) @(posedge i_ref_clk);
      rd(8'h2C);
      chk("acc fail", rv != 32'h0, f[0]);
    end
    i_builtin_self_test_fault <= 1'h0;
    warm_p();
    rc(8'h00, 32'h220);
    $display("test self-test done");
    wr(8'h3C, 32'h1);
    rd(8'h38);
    cnt0 = rv;
    i_clk_en <= 1'h0;
    repeat (5) @(posedge i_ref_clk);
    i_clk_en <= 1'h1;
    rd(8'h38);
    chk("freeze", rv - cnt0, 32'h3);
    $display("test clock enable done");
    rd(8'h80);
    chk("rresp", resp, 32'h2);
    chk("rdata", rv, 32'h0);
    wr(8'h80, 32'h1);
    chk("bresp", resp, 32'h2);
    $display("test unmapped done");
    end_sim();
  end
endmodule
